// ### serial_io_pkg.sv
// Package for the serial baud generator and synchronous I/O conditioning.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package serial_io_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_DIV_HIGH = 8'hFC;
   localparam logic [7:0] IDX_DIV_LOW = 8'hFD;
   localparam logic [7:0] IDX_SYNC_IN = 8'hFE;
   localparam logic [7:0] IDX_SYNC_OUT = 8'hFF;
   localparam logic [7:0] IDX_CORE_CTRL = 8'hF0;
   localparam logic [7:0] IDX_STATUS = 8'hF1;
   localparam logic [11:0] ADDR_DIV_HIGH = {2'h0, IDX_DIV_HIGH, 2'h0};
   localparam logic [11:0] ADDR_DIV_LOW = {2'h0, IDX_DIV_LOW, 2'h0};
   localparam logic [11:0] ADDR_SYNC_IN = {2'h0, IDX_SYNC_IN, 2'h0};
   localparam logic [11:0] ADDR_SYNC_OUT = {2'h0, IDX_SYNC_OUT, 2'h0};
   localparam logic [11:0] ADDR_CORE_CTRL = {2'h0, IDX_CORE_CTRL, 2'h0};
   localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   // Reset values
   localparam logic [7:0] RST_SYNC_IN = 8'h03;
   localparam logic [7:0] RST_SYNC_OUT = 8'h01;
   localparam logic [7:0] RST_CORE_CTRL = 8'h00;
   localparam logic [7:0] RST_DIV = 8'h00;
   // Sync input control fields
   localparam int SI_MODE_EN = 7;
   localparam int SI_RX_INV = 6;
   localparam int SI_RECEIVE_CLOCK_PIN_EDGE = 5;
   localparam int SI_CD_GATE = 4;
   localparam int SI_CD_POL = 3;
   localparam int SI_IN_DIS = 2;
   // Sync output control fields
   localparam int SO_TX_INV = 7;
   localparam int SO_TX_IDLE = 6;
   localparam int SO_TXCLK_EDGE = 5;
   localparam int SO_TXCLK_IDLE = 4;
   localparam int SO_FRAME_EN = 3;
   localparam int SO_REQ_POL = 2;
   localparam int SO_TRISTATE = 1;
   // Core control fields
   localparam int CC_STICK = 0;
   localparam int CC_LOOP = 1;
   localparam int CC_ECHO = 2;
   localparam int CC_DIV1X = 3;
   localparam int CC_BRG_SRC = 4;
   localparam int CC_EVEN = 5;
   // Smallest divisor that runs the generator
   localparam logic [15:0] DIV_MIN = 16'h0002;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;

   // Pin-side outputs as one bundle
   typedef struct packed {
      logic sdo;
      logic sdo_oe;
      logic tclk;
      logic tclk_oe;
      logic rts;
      logic rts_oe;
      logic fss;
   } pin_out_t;
endpackage

// ### serial_baud_sync_io_control.sv
// Baud generator, stick parity and synchronous pin conditioning of a UART.
// Assumes pins synchronous to pclk and a transmit/receive core alongside.
`timescale 1ns/10ps
`default_nettype none
module serial_baud_sync_io_control
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic serial_data_input_pin,
   input wire logic receive_clock_pin,
   input wire logic carrier_detect_pin,
   output serial_io_pkg::pin_out_t pins,
   // Transmitter core
   input wire logic tx_shift_data,
   input wire logic tx_busy,
   input wire logic tx_first_bit,
   input wire logic tx_clk_phase,
   // Receiver core
   output logic rx_data,
   output logic rx_clk_tick,
   output logic bit_tick,
   output logic brg_tick,
   output logic parity_even
);
   typedef enum logic [1:0] {IDLE, ACTIVE} frame_t;

   logic [7:0] div_hi_q, div_lo_q, sync_in_q, sync_out_q, ctrl_q;
   logic [15:0] cnt_q, cnt_d;
   logic [3:0] os_q, os_d;
   logic div_wr_q;
   logic receive_clock_pin_q, brg_tick_q, bit_tick_q, rx_tick_q, rx_data_q, par_q;
   frame_t frame_q, frame_d;
   serial_io_pkg::pin_out_t pins_q, pins_d;
   logic [31:0] rdata_q;

   // Bus decode
   wire wr_en = psel && penable && pwrite;
   wire rd_en = psel && !penable && !pwrite;
   wire hit_hi = paddr == serial_io_pkg::ADDR_DIV_HIGH;
   wire hit_lo = paddr == serial_io_pkg::ADDR_DIV_LOW;
   wire hit_si = paddr == serial_io_pkg::ADDR_SYNC_IN;
   wire hit_so = paddr == serial_io_pkg::ADDR_SYNC_OUT;
   wire hit_cc = paddr == serial_io_pkg::ADDR_CORE_CTRL;
   wire hit_st = paddr == serial_io_pkg::ADDR_STATUS;
   wire hit_any = hit_hi | hit_lo | hit_si | hit_so | hit_cc | hit_st;

   // Effective controls; sync settings count only in sync mode
   wire sync_on = sync_in_q[serial_io_pkg::SI_MODE_EN];
   wire echo = ctrl_q[serial_io_pkg::CC_ECHO];
   wire loop = ctrl_q[serial_io_pkg::CC_LOOP];
   wire in_dis = sync_on && sync_in_q[serial_io_pkg::SI_IN_DIS];
   wire sdi = in_dis ? 1'b0 : serial_data_input_pin;
   wire rclk = in_dis ? 1'b0 : receive_clock_pin;
   wire cdet = in_dis ? 1'b0 : carrier_detect_pin;
   wire rx_inv = sync_on && !loop && sync_in_q[serial_io_pkg::SI_RX_INV];
   wire rx_fall = sync_on && !loop &&
      sync_in_q[serial_io_pkg::SI_RECEIVE_CLOCK_PIN_EDGE];
   wire cd_gate = sync_on && !loop && sync_in_q[serial_io_pkg::SI_CD_GATE];
   wire cd_pol = sync_in_q[serial_io_pkg::SI_CD_POL];
   wire cd_active = cd_pol ? cdet : !cdet;
   wire tx_inv = sync_on && !loop && sync_out_q[serial_io_pkg::SO_TX_INV];
   wire tx_idle = !(sync_on && sync_out_q[serial_io_pkg::SO_TX_IDLE]);
   wire tclk_fall = sync_on && !loop &&
      sync_out_q[serial_io_pkg::SO_TXCLK_EDGE];
   wire tclk_idle = !(sync_on && sync_out_q[serial_io_pkg::SO_TXCLK_IDLE]);
   wire frame_en = sync_on && sync_out_q[serial_io_pkg::SO_FRAME_EN];
   wire req_pol = sync_on && !loop && sync_out_q[serial_io_pkg::SO_REQ_POL];
   wire tri_on = sync_on && sync_out_q[serial_io_pkg::SO_TRISTATE];

   // Receive clock edges
   wire rx_rise = rclk && !receive_clock_pin_q;
   wire rx_fall_e = !rclk && receive_clock_pin_q;
   wire rx_edge = rx_fall ? rx_fall_e : rx_rise;
   wire rx_gate = !cd_gate || cd_active;

   // Baud generator
   wire [15:0] divisor = {div_hi_q, div_lo_q};
   wire brg_run = divisor >= serial_io_pkg::DIV_MIN;
   wire brg_src = ctrl_q[serial_io_pkg::CC_BRG_SRC] ? rx_rise : 1'b1;
   wire brg_hit = brg_run && brg_src && cnt_q == 16'h0001;
   wire div1x = ctrl_q[serial_io_pkg::CC_DIV1X];

   always_comb
   begin
      cnt_d = cnt_q;
      if (div_wr_q || !brg_run)
      begin
         cnt_d = divisor;
      end
      else if (brg_src)
      begin
         cnt_d = brg_hit ? divisor : 16'(cnt_q - 16'h0001);
      end
   end

   always_comb
   begin
      os_d = os_q;
      if (!brg_run)
      begin
         os_d = 4'h0;
      end
      else if (brg_hit)
      begin
         os_d = 4'(os_q + 4'h1);
      end
   end
   wire bit_hit = brg_hit && (div1x ||
      os_q == serial_io_pkg::OVERSAMPLE_LAST);

   // Frame tracking for request-to-send
   always_comb
   begin
      case (frame_q)
         IDLE: frame_d = (frame_en && tx_busy) ? ACTIVE : IDLE;
         ACTIVE: frame_d = (frame_en && tx_busy) ? ACTIVE : IDLE;
         default: frame_d = IDLE;
      endcase
   end
   wire req_act = frame_en && tx_busy;

   // Pin selection
   wire tx_bit = tx_busy ? (tx_shift_data ^ tx_inv) : tx_idle;
   wire tx_clk_raw = tx_busy ? (tx_clk_phase ^ tclk_fall) : tclk_idle;
   always_comb
   begin
      pins_d = '0;
      if (loop)
      begin
         pins_d.sdo = 1'b1;
      end
      else if (echo)
      begin
         pins_d.sdo = serial_data_input_pin;
      end
      else
      begin
         pins_d.sdo = tx_bit;
      end
      pins_d.tclk = echo ? receive_clock_pin : tx_clk_raw;
      if (echo)
      begin
         pins_d.rts = carrier_detect_pin;
      end
      else
      begin
         pins_d.rts = req_act ? req_pol : !req_pol;
      end
      pins_d.fss = frame_en && tx_busy && tx_first_bit;
      pins_d.sdo_oe = !tri_on;
      pins_d.tclk_oe = !tri_on;
      pins_d.rts_oe = !tri_on;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_hi_q <= serial_io_pkg::RST_DIV;
         div_lo_q <= serial_io_pkg::RST_DIV;
         sync_in_q <= serial_io_pkg::RST_SYNC_IN;
         sync_out_q <= serial_io_pkg::RST_SYNC_OUT;
         ctrl_q <= serial_io_pkg::RST_CORE_CTRL;
      end
      else if (wr_en)
      begin
         if (hit_hi) div_hi_q <= pwdata[7:0];
         if (hit_lo) div_lo_q <= pwdata[7:0];
         if (hit_si) sync_in_q <= pwdata[7:0];
         if (hit_so) sync_out_q <= pwdata[7:0];
         if (hit_cc) ctrl_q <= pwdata[7:0];
      end
   end

   wire [31:0] rd_mux =
      hit_hi ? {24'h000000, div_hi_q} :
      hit_lo ? {24'h000000, div_lo_q} :
      hit_si ? {24'h000000, sync_in_q[7:2], 2'h0} :
      hit_so ? {24'h000000, sync_out_q[7:1], 1'h0} :
      hit_cc ? {26'h0000000, ctrl_q[5:0]} :
      hit_st ? {28'h0000000, brg_run, frame_q == ACTIVE, os_q[1:0]} :
      32'h00000000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_q <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         if (rd_en) rdata_q <= rd_mux;
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit_any;
      end
   end
   assign prdata = rdata_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 16'h0000;
         os_q <= 4'h0;
         div_wr_q <= 1'b0;
         receive_clock_pin_q <= 1'b0;
         brg_tick_q <= 1'b0;
         bit_tick_q <= 1'b0;
         rx_tick_q <= 1'b0;
         rx_data_q <= 1'b0;
         par_q <= 1'b0;
         frame_q <= IDLE;
         pins_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
         os_q <= os_d;
         div_wr_q <= wr_en && (hit_hi || hit_lo);
         receive_clock_pin_q <= rclk;
         brg_tick_q <= brg_hit;
         bit_tick_q <= bit_hit;
         rx_tick_q <= rx_edge && rx_gate;
         rx_data_q <= loop ? tx_shift_data : (sdi ^ rx_inv);
         par_q <= ctrl_q[serial_io_pkg::CC_EVEN] ^
            ctrl_q[serial_io_pkg::CC_STICK];
         frame_q <= frame_d;
         pins_q <= pins_d;
      end
   end
   assign pins = pins_q;
   assign rx_data = rx_data_q;
   assign rx_clk_tick = rx_tick_q;
   assign bit_tick = bit_tick_q;
   assign brg_tick = brg_tick_q;
   assign parity_even = par_q;

   // Multi-step sequences
   sequence div_write_s;
      wr_en && (hit_hi || hit_lo);
   endsequence
   sequence div_reload_s;
      ##1 div_wr_q ##1 cnt_q == $past(divisor);
   endsequence
   sequence first_bit_s;
      frame_en && tx_busy && tx_first_bit;
   endsequence
   sequence strobe_up_s;
      ##1 pins.fss;
   endsequence

   // Output and state checks
   stick_parity_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      parity_even == $past(ctrl_q[serial_io_pkg::CC_EVEN] ^
      ctrl_q[serial_io_pkg::CC_STICK]))
      else $error("parity select wrong");
   brg_halt_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !$past(brg_run) |-> !brg_tick)
      else $error("halted generator ticked");
   div_load_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      div_wr_q |=> cnt_q == $past(divisor))
      else $error("divisor not loaded");
   loop_high_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(loop) |-> pins.sdo)
      else $error("loop output not high");
   tristate_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(tri_on) |->
      !pins.sdo_oe && !pins.tclk_oe && !pins.rts_oe)
      else $error("outputs not floated");
   echo_data_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(echo && !loop) |->
      pins.sdo == $past(serial_data_input_pin))
      else $error("echo data wrong");
   strobe_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      pins.fss |-> $past(frame_en && tx_first_bit))
      else $error("frame strobe wrong");
   sync_off_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn && !sync_on && !loop && !echo && !tx_busy) |->
      pins.sdo)
      else $error("sync bits not ignored");
   rx_invert_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn && !loop && !in_dis) |->
      rx_data == $past(serial_data_input_pin ^ rx_inv))
      else $error("receive data polarity wrong");
   rx_gate_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(cd_gate && !cd_active) |-> !rx_clk_tick)
      else $error("receive clock passed without carrier");
   tx_invert_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn && tx_busy && !loop && !echo) |->
      pins.sdo == $past(tx_shift_data ^ tx_inv))
      else $error("transmit data polarity wrong");
   tx_idle_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn && !tx_busy && !loop && !echo) |->
      pins.sdo == !$past(sync_on && sync_out_q[serial_io_pkg::SO_TX_IDLE]))
      else $error("transmit idle level wrong");
   tx_clock_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn && tx_busy && !echo) |->
      pins.tclk == $past(tx_clk_phase ^ tclk_fall))
      else $error("transmit clock edge wrong");
   tclk_idle_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn && !tx_busy && !echo) |->
      pins.tclk == !$past(sync_on &&
      sync_out_q[serial_io_pkg::SO_TXCLK_IDLE]))
      else $error("transmit clock idle level wrong");
   req_level_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn && frame_en && tx_busy && !echo) |->
      pins.rts == $past(req_pol))
      else $error("request level wrong");
   echo_clock_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn && echo) |-> pins.tclk == $past(receive_clock_pin) &&
      pins.rts == $past(carrier_detect_pin))
      else $error("echo clock or request wrong");
   strobe_low_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !$past(tx_first_bit) |-> !pins.fss)
      else $error("frame strobe past first bit");
   strobe_on_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      first_bit_s |-> strobe_up_s)
      else $error("frame strobe missing");
   div_reload_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      div_write_s |-> div_reload_s)
      else $error("divisor write not reloaded");
   count_down_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      brg_run && brg_src && !div_wr_q && cnt_q > 16'h0001 |=>
      cnt_q == 16'($past(cnt_q) - 16'h0001))
      else $error("counter did not count down");
   bit_tick_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      bit_tick |-> brg_tick)
      else $error("bit tick without generator tick");
endmodule // serial_baud_sync_io_control
`default_nettype wire

// ### serial_far_end.sv
// Far-end serial device model: one framed burst of receive clock.
// Assumes start is a one-cycle pulse from the bench.
`timescale 1ns/10ps
`default_nettype none
module serial_far_end
(
   // Clock, reset, control
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic idle_bit,
   // Lines toward the device
   output logic sdi,
   output logic rclk,
   output logic dcd
);
   logic [6:0] cnt_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= 7'h00;
      else if (start)
         cnt_q <= 7'h40;
      else if (cnt_q != 7'h00)
         cnt_q <= cnt_q - 7'h01;
   end
   // Carrier high in frame; clock still outside it
   assign dcd = (cnt_q != 7'h00);
   assign rclk = dcd & cnt_q[2];
   assign sdi = dcd ? cnt_q[3] : idle_bit;
endmodule // serial_far_end
`default_nettype wire

// ### serial_baud_sync_io_control_bench.sv
// Testbench: APB register tests of baud and sync pin control.
// Assumes the far-end model drives the three input pins.
`timescale 1ns/10ps
`default_nettype none
module serial_baud_sync_io_control_bench;
   localparam logic [11:0] a_dh = serial_io_pkg::ADDR_DIV_HIGH;
   localparam logic [11:0] a_dl = serial_io_pkg::ADDR_DIV_LOW;
   localparam logic [11:0] a_si = serial_io_pkg::ADDR_SYNC_IN;
   localparam logic [11:0] a_so = serial_io_pkg::ADDR_SYNC_OUT;
   localparam logic [11:0] a_cc = serial_io_pkg::ADDR_CORE_CTRL;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, sdi, rclk, dcd;
   logic start = 1'b0;
   logic idle_bit = 1'b1;
   logic tx_d = 1'b0;
   logic tx_busy = 1'b0;
   logic tx_first = 1'b0;
   logic tx_ph = 1'b0;
   logic rx_data, rx_tick, bit_tick, brg_tick, par_even;
   serial_io_pkg::pin_out_t pins;
   logic [7:0] rc [4] = '{8'h98, 8'hB8, 8'h90, 8'h9C};
   int rx_exp [4] = '{8, 8, 0, 0};
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [31:0] nb, nt, nr;
   always #50 pclk = ~pclk;
   serial_far_end far (.pclk(pclk), .presetn(presetn), .start(start),
      .idle_bit(idle_bit), .sdi(sdi), .rclk(rclk), .dcd(dcd));
   serial_baud_sync_io_control dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_data_input_pin(sdi),
      .receive_clock_pin(rclk), .carrier_detect_pin(dcd), .pins(pins),
      .tx_shift_data(tx_d), .tx_busy(tx_busy), .tx_first_bit(tx_first),
      .tx_clk_phase(tx_ph), .rx_data(rx_data), .rx_clk_tick(rx_tick),
      .bit_tick(bit_tick), .brg_tick(brg_tick), .parity_even(par_even));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic count(input int c);
      nb = 0;
      nt = 0;
      nr = 0;
      repeat (c)
      begin
         @(negedge pclk);
         nb += brg_tick;
         nt += bit_tick;
         nr += rx_tick;
      end
   endtask
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, a_si, 0);
      chk("sync_in", rd, 32'h0);
      apb(0, a_so, 0);
      chk("sync_out", rd, 32'h0);
      apb(0, 12'h004, 0);
      chk("slverr", err, 32'h1);
      $display("end registers");
      for (int i = 0; i < 4; i++)
      begin
         apb(1, a_cc, {26'h0, i[1], 4'h0, i[0]});
         settle();
         chk("parity_even", par_even, i[1] ^ i[0]);
      end
      $display("end parity");
      apb(1, a_cc, 32'h08);
      apb(1, a_dh, 32'hFF);
      apb(1, a_dl, 32'hFF);
      apb(1, a_dh, 32'h00);
      apb(1, a_dl, 32'h03);
      settle();
      count(30);
      chk("brg", nb, 10);
      chk("bit 1x", nt, 10);
      apb(0, a_dl, 0);
      chk("div_low", rd, 32'h03);
      apb(1, a_cc, 32'h00);
      apb(1, a_dl, 32'h02);
      settle();
      count(96);
      chk("brg", nb, 48);
      chk("bit 16x", nt, 3);
      apb(1, a_cc, 32'h10);
      settle();
      count(30);
      chk("brg ext", nb, 0);
      apb(1, a_cc, 32'h00);
      for (int i = 0; i < 2; i++)
      begin
         apb(1, a_dl, i);
         settle();
         count(30);
         chk("brg halt", nb, 0);
      end
      $display("end baud");
      apb(1, a_so, 32'h50);
      settle();
      chk("sdo", pins.sdo, 1);
      chk("tclk", pins.tclk, 1);
      apb(1, a_si, 32'h80);
      settle();
      chk("sdo", pins.sdo, 0);
      chk("tclk", pins.tclk, 0);
      apb(1, a_so, 32'h02);
      settle();
      chk("oe", {pins.sdo_oe, pins.tclk_oe, pins.rts_oe}, 0);
      apb(1, a_so, 32'h0C);
      tx_busy <= 1'b1;
      tx_first <= 1'b1;
      settle();
      chk("oe", {pins.sdo_oe, pins.tclk_oe, pins.rts_oe}, 7);
      chk("rts", pins.rts, 1);
      chk("fss", pins.fss, 1);
      tx_first <= 1'b0;
      settle();
      chk("fss", pins.fss, 0);
      apb(1, a_so, 32'h88);
      tx_d <= 1'b1;
      tx_ph <= 1'b1;
      settle();
      chk("rts low", pins.rts, 0);
      chk("sdo inv", pins.sdo, 0);
      chk("tclk rise", pins.tclk, 1);
      apb(1, a_so, 32'hA8);
      settle();
      chk("tclk fall", pins.tclk, 0);
      tx_busy <= 1'b0;
      settle();
      chk("rts idle", pins.rts, 1);
      chk("tclk idle", pins.tclk, 1);
      $display("end outputs");
      apb(1, a_cc, 32'h04);
      apb(1, a_si, 32'hC0);
      for (int i = 0; i < 2; i++)
      begin
         idle_bit <= i[0];
         settle();
         chk("echo", pins.sdo, i[0]);
         chk("rx_data", rx_data, !i[0]);
      end
      apb(1, a_cc, 32'h02);
      idle_bit <= 1'b0;
      settle();
      chk("loop", pins.sdo, 1);
      apb(1, a_cc, 32'h00);
      apb(1, a_si, 32'h84);
      idle_bit <= 1'b1;
      settle();
      chk("rx off", rx_data, 0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1, a_si, rc[i]);
         @(posedge pclk);
         start <= 1'b1;
         @(posedge pclk);
         start <= 1'b0;
         count(80);
         chk("rx ticks", nr, rx_exp[i]);
      end
      $display("end inputs");
      end_sim();
   end
endmodule // serial_baud_sync_io_control_bench
`default_nettype wire
